// ===== rtl/rdbus_pkg.sv
// Purpose: Shared constants for the boot buffer and local bus pin mux
// Assumes: 25 MHz CLK, APB slave with 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package rdbus_pkg;
   localparam int          CLK_HZ          = 25_000_000;
   localparam int          BUS_W           = 8;
   localparam int          KBC_LO          = 2;                 // First port-capable bit
   localparam logic [7:0]  KBC_CAP_MASK    = 8'hFC;             // Bits 2..7 take port function
   // Strong-high hold after a rise, in nanoseconds, and its cycle count (rounded down)
   localparam int          BOOST_NS        = 120;
   localparam int          BOOST_CYC_RAW   = (BOOST_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int          BOOST_CYC       = (BOOST_CYC_RAW < 1) ? 1 : BOOST_CYC_RAW;
   localparam int          BOOST_W         = 4;
   localparam logic [BOOST_W-1:0] BOOST_LOAD = BOOST_W'(BOOST_CYC);
   // Register offsets
   localparam logic [11:0] OFS_CTRL        = 12'h000;
   localparam logic [11:0] OFS_ALT_EN      = 12'h004;
   localparam logic [11:0] OFS_KBC_SEL     = 12'h008;
   localparam logic [11:0] OFS_GP_DIR      = 12'h00C;
   localparam logic [11:0] OFS_GP_INV      = 12'h010;
   localparam logic [11:0] OFS_GP_OUT      = 12'h014;
   localparam logic [11:0] OFS_KBC_PORT    = 12'h018;
   localparam logic [11:0] OFS_KBC_OD      = 12'h01C;
   localparam logic [11:0] OFS_PIN_STATE   = 12'h020;
   // Control register fields
   localparam int          CTRL_SEL_ALT    = 0;
   localparam int          CTRL_OE_ALT     = 1;
   localparam int          CTRL_W          = 2;
   // Reset values: all pins plain non-inverting inputs
   localparam logic [7:0]  RST_ALT_EN      = 8'h00;
   localparam logic [7:0]  RST_GP_DIR      = 8'hFF;             // 1 = input
   localparam logic [7:0]  RST_GP_INV      = 8'h00;
   localparam logic [7:0]  RST_ZERO8       = 8'h00;
   localparam logic [7:0]  RST_KBC_PORT    = 8'hFF;
   localparam logic [CTRL_W-1:0] RST_CTRL  = 2'h0;
endpackage

// ===== rtl/rdbus_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to CLK
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ns
module rdbus_sync #(
   parameter int W = 8
) (
   input  wire logic         CLK,      // System clock
   input  wire logic         RST_N,    // Async reset, active low
   input  wire logic [W-1:0] d_async,  // Raw pin levels
   output logic      [W-1:0] q         // Filtered levels
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   wire  [W-1:0] agree = ~(s2_q ^ s3_q);

   // First stage feeds only the second
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         q    <= '0;
      end else begin
         s1_q <= d_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q    <= (agree & s3_q) | (~agree & q);
      end
   end
endmodule

// ===== rtl/boot_buffer_rd_bus_mux.sv
// Purpose: Boot ROM byte buffer between system and local bus, plus pin sharing
// Assumes: APB register access, 25 MHz CLK, buffer controls are async pins
// Notes:   Buffer controls pass the pin filter; outputs registered; drive enables active low, pull-up enables active high
`timescale 1ns/1ns

// Operation
// - select low, direction low: local to system
// - select low, direction high: system to local
// - select high isolates both buses
// - local-to-system copies every pin incl. alternates
// - system-to-local: alternate pins drive alternate value
// - output-enable redefined: read-only local bus
// - read-only, select high: system bus undriven
// - read-only: alternate pins still copied
// - select redefined: forced high, bus floats
// - both redefined behaves as select redefined
// - bits two-seven offer keyboard port bits
// - push-pull: one rises with strong drive
// - strong drive ends, pull-up holds high
// - open-drain: one tristates, zero drives low
// - port function ignores direction and inversion
// - each pin plain I/O or alternate
// - reset: all pins non-inverting inputs
module boot_buffer_rd_bus_mux
   import rdbus_pkg::*;
(
   input  wire logic                     CLK,                       // 25 MHz clock
   input  wire logic                     RST_N,                     // Async reset, active low
   input  wire logic                     BOOT_BUFFER_SELECT_N,      // Buffer enable pin
   input  wire logic                     BUFFER_DIRECTION_N,        // Low: local to system
   input  wire logic [rdbus_pkg::BUS_W-1:0] SYSTEM_DATA_BUS_I,      // System bus pin level
   output logic      [rdbus_pkg::BUS_W-1:0] SYSTEM_DATA_BUS_O,      // System bus drive value
   output logic                          SYSTEM_DATA_BUS_OE_N,      // Low: drive system bus
   input  wire logic [rdbus_pkg::BUS_W-1:0] LOCAL_BUS_I,            // Local pin levels
   output logic      [rdbus_pkg::BUS_W-1:0] LOCAL_BUS_O,            // Local pin drive value
   output logic      [rdbus_pkg::BUS_W-1:0] LOCAL_BUS_OE_N,         // Per pin, low: drive
   output logic      [rdbus_pkg::BUS_W-1:0] LOCAL_PULLUP_EN,        // Weak pull-up enables
   output logic                          BOOT_OUTPUT_ENABLE_N,      // ROM output enable pin
   input  wire logic                     PSEL,                      // APB select
   input  wire logic                     PENABLE,                   // APB enable
   input  wire logic                     PWRITE,                    // APB direction
   input  wire logic [11:0]              PADDR,                     // APB byte address
   input  wire logic [31:0]              PWDATA,                    // APB write data
   output logic      [31:0]              PRDATA,                    // APB read data
   output logic                          PREADY,                    // APB ready
   output logic                          PSLVERR                    // APB error
);
   // Software-visible configuration
   logic [CTRL_W-1:0] ctrl_q;
   logic [BUS_W-1:0]  alt_en_q;
   logic [BUS_W-1:0]  kbc_sel_q;
   logic [BUS_W-1:0]  gp_dir_q;
   logic [BUS_W-1:0]  gp_inv_q;
   logic [BUS_W-1:0]  gp_out_q;
   logic [BUS_W-1:0]  kbc_port_q;
   logic [BUS_W-1:0]  kbc_od_q;

   // Port rise tracking and strong-drive window
   logic [BUS_W-1:0]  kbc_prev_q;
   logic [BUS_W-1:0]  boost_act;

   // Filtered pin views
   logic [BUS_W-1:0]  local_sync;
   logic [1:0]        ctl_inv_sync;   // Inverted controls, zero after reset

   // Filtered local pins for readback; filtered controls also steer the buffer
   rdbus_sync #(.W(BUS_W)) u_sync_local (
      .CLK     (CLK),
      .RST_N   (RST_N),
      .d_async (LOCAL_BUS_I),
      .q       (local_sync)
   );
   rdbus_sync #(.W(2)) u_sync_ctl (
      .CLK     (CLK),
      .RST_N   (RST_N),
      .d_async ({~BUFFER_DIRECTION_N, ~BOOT_BUFFER_SELECT_N}),
      .q       (ctl_inv_sync)
   );

   // Controls pass the filter inverted: the filter flops reset to zero, which
   // then reads as the idle high level, so the buffer stays shut after reset
   wire [1:0] ctl_sync  = ~ctl_inv_sync;
   wire       sel_pin_n = ctl_sync[0];
   wire       dir_pin_n = ctl_sync[1];

   // APB decode
   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   wire acc      = PSEL && PENABLE && !PREADY;
   // Writes land on the edge that completes the transfer, with ready high,
   // so a register never changes before the bus has acknowledged it
   wire wr_done  = PSEL && PENABLE && PREADY && PWRITE;
   wire sel_ctrl = hit(PADDR, OFS_CTRL);
   wire sel_alt  = hit(PADDR, OFS_ALT_EN);
   wire sel_ksel = hit(PADDR, OFS_KBC_SEL);
   wire sel_dir  = hit(PADDR, OFS_GP_DIR);
   wire sel_inv  = hit(PADDR, OFS_GP_INV);
   wire sel_out  = hit(PADDR, OFS_GP_OUT);
   wire sel_kp   = hit(PADDR, OFS_KBC_PORT);
   wire sel_kod  = hit(PADDR, OFS_KBC_OD);
   wire sel_pin  = hit(PADDR, OFS_PIN_STATE);
   wire mapped   = sel_ctrl | sel_alt | sel_ksel | sel_dir | sel_inv | sel_out
                 | sel_kp | sel_kod | sel_pin;

   wire [31:0] rd_mux =
        sel_ctrl ? {30'h0, ctrl_q} :
        sel_alt  ? {24'h0, alt_en_q} :
        sel_ksel ? {24'h0, kbc_sel_q} :
        sel_dir  ? {24'h0, gp_dir_q} :
        sel_inv  ? {24'h0, gp_inv_q} :
        sel_out  ? {24'h0, gp_out_q} :
        sel_kp   ? {24'h0, kbc_port_q} :
        sel_kod  ? {24'h0, kbc_od_q} :
        sel_pin  ? {22'h0, ctl_sync, local_sync} : 32'h0;

   // APB answer one cycle after the access phase opens
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= acc;
         PSLVERR <= acc && !mapped;
      end
   end

   // Read data held until the next read, so a slow master still sees it
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         PRDATA <= 32'h0;
      else if (acc && !PWRITE)
         PRDATA <= rd_mux;
   end

   // per-pin function select; reset as plain non-inverting inputs
   // Each register has its own short process, written only at the ready edge
   // Pin control: bit0 select redefined, bit1 output enable redefined
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         ctrl_q <= RST_CTRL;
      else if (wr_done && sel_ctrl)
         ctrl_q <= PWDATA[CTRL_W-1:0];
   end

   // Alternate function enable, one bit per pin
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         alt_en_q <= RST_ALT_EN;
      else if (wr_done && sel_alt)
         alt_en_q <= PWDATA[BUS_W-1:0];
   end

   // only bits two to seven carry the port function
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         kbc_sel_q <= RST_ZERO8;
      else if (wr_done && sel_ksel)
         kbc_sel_q <= PWDATA[BUS_W-1:0] & KBC_CAP_MASK;
   end

   // Plain pin direction, one means input
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         gp_dir_q <= RST_GP_DIR;
      else if (wr_done && sel_dir)
         gp_dir_q <= PWDATA[BUS_W-1:0];
   end

   // Plain pin polarity inversion
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         gp_inv_q <= RST_GP_INV;
      else if (wr_done && sel_inv)
         gp_inv_q <= PWDATA[BUS_W-1:0];
   end

   // Plain pin output levels
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         gp_out_q <= RST_ZERO8;
      else if (wr_done && sel_out)
         gp_out_q <= PWDATA[BUS_W-1:0];
   end

   // Port bits, idle high like an unloaded port
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         kbc_port_q <= RST_KBC_PORT;
      else if (wr_done && sel_kp)
         kbc_port_q <= PWDATA[BUS_W-1:0];
   end

   // Port drive style, one means open drain
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         kbc_od_q <= RST_ZERO8;
      else if (wr_done && sel_kod)
         kbc_od_q <= PWDATA[BUS_W-1:0];
   end

   // per-bit strong-high window after each push-pull port rise
   genvar g;
   generate
      for (g = 0; g < BUS_W; g++) begin : g_boost
         logic [BOOST_W-1:0] cnt_q;
         wire rise = kbc_port_q[g] && !kbc_prev_q[g] && !kbc_od_q[g];
         always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
               cnt_q <= '0;
            end else if (rise) begin
               cnt_q <= BOOST_LOAD;
            end else if (cnt_q != '0) begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
         // Rise cycle drives too, so the pin never drops to the pull-up first;
         // open-drain bits never start a window
         assign boost_act[g] = rise || (cnt_q != '0);
      end
   endgenerate

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         kbc_prev_q <= RST_KBC_PORT;
      else
         kbc_prev_q <= kbc_port_q;
   end

   // Controls come from the filter: pin to output takes about five clocks
   // redefined select reads as high internally
   wire sel_n_int = ctrl_q[CTRL_SEL_ALT] ? 1'b1 : sel_pin_n;
   // redefined output enable reads as low internally
   wire oe_alt    = ctrl_q[CTRL_OE_ALT] && !ctrl_q[CTRL_SEL_ALT];
   wire buf_on    = !sel_n_int;
   wire to_sys    = buf_on && (oe_alt || !dir_pin_n);
   // system-to-local only with output enable in original function
   wire to_loc    = buf_on && !oe_alt && dir_pin_n;

   // Pin function per bit
   // Limitation: bits zero and one never take the port function
   wire [BUS_W-1:0] kbc_mode = alt_en_q & kbc_sel_q;
   wire [BUS_W-1:0] gp_mode  = alt_en_q & ~kbc_sel_q;

   // One control bit spread over the whole byte
   function automatic logic [BUS_W-1:0] all_bits(input logic b);
      all_bits = {BUS_W{b}};
   endfunction

   // port mode ignores direction and inversion
   // Trade-off: the direction register only gates plain outputs
   wire [BUS_W-1:0] gp_val   = gp_out_q ^ gp_inv_q;
   wire [BUS_W-1:0] alt_drv  = kbc_mode | (gp_mode & ~gp_dir_q);
   wire [BUS_W-1:0] alt_val  = (kbc_mode & kbc_port_q) | (gp_mode & gp_val);
   // open drain never drives high; push-pull high only in window
   wire [BUS_W-1:0] kbc_oe   = ~kbc_port_q | (boost_act & ~kbc_od_q);
   wire [BUS_W-1:0] alt_oe   = (kbc_mode & kbc_oe) | (gp_mode & ~gp_dir_q);

   // alternates keep their own value; other pins take system data
   wire [BUS_W-1:0] loc_drv  = alt_en_q | all_bits(to_loc);
   wire [BUS_W-1:0] loc_val  = (alt_en_q & alt_val) | (~alt_en_q & SYSTEM_DATA_BUS_I);
   wire [BUS_W-1:0] loc_en   = (alt_en_q & alt_oe & alt_drv) | (~alt_en_q & all_bits(to_loc));

   // every local pin copied, alternates included; nothing when off
   wire [BUS_W-1:0] sys_val  = LOCAL_BUS_I;

   // Outputs registered to keep the pins glitch-free; the price is that the
   // buffer enables follow the filtered controls one clock later still.
   // System side drive and enable
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         SYSTEM_DATA_BUS_O    <= RST_ZERO8;
         SYSTEM_DATA_BUS_OE_N <= 1'b1;
      end else begin
         SYSTEM_DATA_BUS_O    <= sys_val;
         SYSTEM_DATA_BUS_OE_N <= !to_sys;
      end
   end

   // Local side drive, enables and pull-ups
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         LOCAL_BUS_O          <= RST_ZERO8;
         LOCAL_BUS_OE_N       <= 8'hFF;
         LOCAL_PULLUP_EN      <= RST_ZERO8;
      end else begin
         LOCAL_BUS_O          <= loc_val;
         LOCAL_BUS_OE_N       <= ~(loc_en & loc_drv);
         // weak pull-up on push-pull port bits
         LOCAL_PULLUP_EN      <= kbc_mode & ~kbc_od_q;
      end
   end

   // ROM output enable, held high while its pin serves another function
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         BOOT_OUTPUT_ENABLE_N <= 1'b1;
      else
         BOOT_OUTPUT_ENABLE_N <= ctrl_q[CTRL_OE_ALT] ? 1'b1 : !to_sys;
   end
endmodule

// ===== bench/rdbus_partner.sv
// Purpose: Host data bus and boot ROM facing the mux
// Assumes: Host drives whenever the device releases
// Notes:   Floating local lines invert their last level
`timescale 1ns/1ns
module rdbus_partner (
   input  wire logic       clk,      // Clock
   input  wire logic [7:0] sys_o,    // Device system drive
   input  wire logic       sys_oe_n, // Low: device drives
   input  wire logic [7:0] loc_o,    // Device local drive
   input  wire logic [7:0] loc_oe_n, // Per bit, low: drive
   input  wire logic [7:0] pu_en,    // Device pull-ups
   input  wire logic [7:0] host_val, // Host byte
   input  wire logic [7:0] rom_val,  // ROM byte
   input  wire logic       rom_en,   // ROM drives local bus
   output logic      [7:0] sys_lvl,  // System wire level
   output logic      [7:0] loc_lvl   // Local wire level
);
   logic [7:0] last_q;
   // Last level, so a floating line never repeats it
   always_ff @(posedge clk) begin
      last_q <= loc_lvl;
   end
   // Wire levels from all drivers
   assign sys_lvl = sys_oe_n ? host_val : sys_o;
   assign loc_lvl = (~loc_oe_n & loc_o) | (loc_oe_n & (rom_en ? rom_val : (pu_en | ~last_q)));
endmodule

// ===== bench/rdbus_chk_asserts.sv
// Purpose: Port checks for the boot buffer mux
// Assumes: Controls steady six cycles before a check
// Notes:   Control bits are copied by watching APB writes
`timescale 1ns/1ns
module rdbus_chk
   import rdbus_pkg::*;
(
   input  wire logic        CLK,                  // Clock
   input  wire logic        RST_N,                // Reset, active low
   input  wire logic        BOOT_BUFFER_SELECT_N, // Buffer enable
   input  wire logic        BUFFER_DIRECTION_N,   // Direction
   input  wire logic        SYSTEM_DATA_BUS_OE_N, // System drive
   input  wire logic        PSEL,                 // APB select
   input  wire logic        PENABLE,              // APB enable
   input  wire logic        PWRITE,               // APB direction
   input  wire logic [11:0] PADDR,                // APB address
   input  wire logic [31:0] PWDATA,               // APB write data
   input  wire logic        PREADY,               // APB ready
   input  wire logic        PSLVERR               // APB error
);
   logic [1:0] ctrl_q;
   wire        ctrl_wr = PSEL & PENABLE & PREADY & PWRITE & (PADDR == OFS_CTRL);
   wire        sel_alt = ctrl_q[CTRL_SEL_ALT];
   wire        oe_alt  = ctrl_q[CTRL_OE_ALT];
   // Copy of the control register, taken at the ready edge
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         ctrl_q <= RST_CTRL;
      else if (ctrl_wr)
         ctrl_q <= PWDATA[1:0];
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Margin covers pin synchroniser plus output register
   sequence s_read;
      (!BOOT_BUFFER_SELECT_N && !sel_alt && (oe_alt || !BUFFER_DIRECTION_N)) [*6];
   endsequence
   sequence s_write;
      (!BOOT_BUFFER_SELECT_N && !sel_alt && !oe_alt && BUFFER_DIRECTION_N) [*6];
   endsequence
   sequence s_access;
      PSEL && PENABLE && !$past(PENABLE);
   endsequence
   a_local_to_sys: assert property (s_read |-> !SYSTEM_DATA_BUS_OE_N)
      else $error("system bus not driven in read direction");
   a_sys_to_local: assert property (s_write |-> SYSTEM_DATA_BUS_OE_N)
      else $error("system bus driven in write direction");
   a_pin_isolates: assert property (BOOT_BUFFER_SELECT_N [*6] |-> SYSTEM_DATA_BUS_OE_N)
      else $error("system bus driven while deselected");
   a_sel_redefined: assert property (sel_alt [*6] |-> SYSTEM_DATA_BUS_OE_N)
      else $error("system bus driven with select redefined");
   a_ready_answer: assert property (s_access |=> PREADY)
      else $error("no ready one cycle into access");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held past one cycle");
   a_unmapped_err: assert property (PREADY && (PADDR > OFS_PIN_STATE) |-> PSLVERR)
      else $error("unmapped access without error");
   a_mapped_ok: assert property (PREADY && (PADDR <= OFS_PIN_STATE) && (PADDR[1:0] == 2'h0)
      |-> !PSLVERR)
      else $error("mapped access flagged as error");
endmodule
bind boot_buffer_rd_bus_mux rdbus_chk i_rdbus_chk (.CLK, .RST_N, .BOOT_BUFFER_SELECT_N,
   .BUFFER_DIRECTION_N, .SYSTEM_DATA_BUS_OE_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
   .PREADY, .PSLVERR);

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the boot buffer mux
// Assumes: APB master with an idle cycle between transfers
// Notes:   Buffer outputs are sampled after eight settling cycles
`timescale 1ns/1ns
module tb_top;
   import rdbus_pkg::*;
   logic        clk = 0, rst_n = 0, sel_n = 1, dir_n = 1, rom_en = 1, er;
   logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, sys_oe_n, boe_n;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0]  sys_lvl, sys_o, loc_lvl, loc_o, loc_oe_n, pu_en;
   logic [7:0]  host_val = 8'h3C, rom_val = 8'hA4;
   int          err_count = 0, num_checks = 0, cyc = 0;
   boot_buffer_rd_bus_mux i_boot_buffer_rd_bus_mux (.CLK(clk), .RST_N(rst_n),
      .BOOT_BUFFER_SELECT_N(sel_n), .BUFFER_DIRECTION_N(dir_n), .SYSTEM_DATA_BUS_I(sys_lvl),
      .SYSTEM_DATA_BUS_O(sys_o), .SYSTEM_DATA_BUS_OE_N(sys_oe_n), .LOCAL_BUS_I(loc_lvl),
      .LOCAL_BUS_O(loc_o), .LOCAL_BUS_OE_N(loc_oe_n), .LOCAL_PULLUP_EN(pu_en),
      .BOOT_OUTPUT_ENABLE_N(boe_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
   rdbus_partner i_rdbus_partner (.clk, .sys_o, .sys_oe_n, .loc_o, .loc_oe_n, .pu_en,
      .host_val, .rom_val, .rom_en, .sys_lvl, .loc_lvl);
   // Clock and hang guard
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         give_verdict;
      end
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   // Idle edge first, so no signal is assigned twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Wait for ready; only the cycle guard ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(rd, x);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task automatic go(input logic s, input logic d);
      sel_n <= s;
      dir_n <= d;
      repeat (8) @(posedge clk);
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rdc(OFS_CTRL, 32'h0);
      rdc(OFS_ALT_EN, 32'h0);
      rdc(OFS_GP_DIR, 32'hFF);
      rdc(OFS_GP_INV, 32'h0);
      rdc(12'h040, 32'h0);
      chk(er, 1'b1);
      $display("test reset done");
      go(1'b0, 1'b0);
      chk(sys_oe_n, 1'b0);
      chk(sys_o, 8'hA4);
      chk(boe_n, 1'b0);
      go(1'b0, 1'b1);
      chk(loc_oe_n, 8'h00);
      chk(loc_o, 8'h3C);
      chk(sys_oe_n, 1'b1);
      go(1'b1, 1'b0);
      chk({sys_oe_n, loc_oe_n}, 9'h1FF);
      $display("test buffer done");
      wr(OFS_ALT_EN, 8'h01);
      wr(OFS_GP_DIR, 8'hFE);
      wr(OFS_GP_INV, 8'h01);
      go(1'b0, 1'b1);
      chk({loc_oe_n[0], loc_o[0]}, 2'h1);
      go(1'b0, 1'b0);
      chk(sys_o, 8'hA5);
      wr(OFS_CTRL, 8'h02);
      go(1'b0, 1'b1);
      chk(sys_oe_n, 1'b0);
      chk(loc_oe_n[7:1], 7'h7F);
      chk(boe_n, 1'b1);
      chk(sys_o, 8'hA5);
      go(1'b1, 1'b1);
      chk(sys_oe_n, 1'b1);
      for (int i = 1; i < 4; i += 2) begin
         wr(OFS_CTRL, 8'(i));
         go(1'b0, 1'b0);
         chk(sys_oe_n, 1'b1);
      end
      $display("test pin sharing done");
      rom_en <= 1'b0;
      wr(OFS_ALT_EN, 8'h05);
      wr(OFS_KBC_SEL, 8'h04);
      wr(OFS_GP_INV, 8'h05);
      wr(OFS_KBC_PORT, 8'hFB);
      repeat (4) @(posedge clk);
      chk({loc_oe_n[2], loc_o[2]}, 2'h0);
      wr(OFS_KBC_PORT, 8'hFF);
      repeat (2) @(posedge clk);
      chk({loc_oe_n[2], loc_o[2]}, 2'h1);
      repeat (6) @(posedge clk);
      chk({loc_oe_n[2], pu_en[2]}, 2'h3);
      wr(OFS_KBC_OD, 8'h04);
      wr(OFS_KBC_PORT, 8'hFB);
      repeat (4) @(posedge clk);
      chk(loc_oe_n[2], 1'b0);
      wr(OFS_KBC_PORT, 8'hFF);
      repeat (2) @(posedge clk);
      chk(loc_oe_n[2], 1'b1);
      $display("test port bits done");
      go(1'b1, 1'b1);
      give_verdict;
   end
endmodule
